// ==== hdl/kww_cfg.svh ====
// offsets, field positions, reset values and counts of the watchdog
`ifndef KWW_CFG_SVH
`define KWW_CFG_SVH
`define KWW_ADDR_CTRL     16'hF600
`define KWW_ADDR_CLR      16'hF604
`define KWW_ADDR_SET      16'hF608
`define KWW_ADDR_INV      16'hF60C
`define KWW_ADDR_STAT     16'hF610
`define KWW_ADDR_STCLR    16'hF614
`define KWW_ADDR_IEN      16'hF618
`define KWW_ADDR_CNT      16'hF61C
`define KWW_KEY           16'h5743
`define KWW_KEY_BE        4'hC
`define KWW_KEY_LSB       16
`define KWW_BIT_ON        15
`define KWW_BIT_WIN       0
`define KWW_RUN_LSB       8
`define KWW_RUN_MSB       12
`define KWW_ON_RST        1'b0
`define KWW_WIN_RST       1'b0
`define KWW_RUN_RST       5'h00
`define KWW_PS_MAX        5'h14
`define KWW_CNT_W         20
`define KWW_EVT_W         4
`define KWW_EVT_RST       4'h0
`endif

// ==== hdl/kww_pkg.sv ====
// types shared by the watchdog files
package kww_pkg;
   typedef logic [4:0] kww_scale_t;
   typedef logic [19:0] kww_count_t;
   // bit positions of the sticky event status
   typedef enum logic [1:0]
   {
      KWW_EVT_TIMEOUT = 2'b00,
      KWW_EVT_WAKE    = 2'b01,
      KWW_EVT_WINDOW  = 2'b10,
      KWW_EVT_BADKEY  = 2'b11
   } kww_evt_t;
endpackage

// ==== hdl/kww_postscale.sv ====
// postscaled tick counter giving the time-out of the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "kww_cfg.svh"
module kww_postscale (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clear,
   input  wire logic              tick,
   input  wire kww_pkg::kww_scale_t scale,
   output logic [`KWW_CNT_W-1:0]  count,
   output logic                   expired,
   output logic                   halfDone
);
   logic [`KWW_CNT_W-1:0] count_ff;
   logic                  expired_ff;
   kww_pkg::kww_scale_t   scaleC;
   logic [`KWW_CNT_W-1:0] terminal;

   // codes above the longest period saturate
   assign scaleC   = (scale > `KWW_PS_MAX) ? `KWW_PS_MAX : scale;
   assign terminal = `KWW_CNT_W'((21'h000001 << scaleC) - 21'h000001);
   assign halfDone = (count_ff >= (terminal >> 1));
   assign count    = count_ff;
   assign expired  = expired_ff;

   // count low-power ticks, wrap on expiry
   always_ff @(posedge clk)
   begin
      if (reset || clear)
         count_ff <= '0;
      else if (tick && (count_ff == terminal))
         count_ff <= '0;
      else if (tick)
         count_ff <= count_ff + `KWW_CNT_W'(1);
   end

   // one-cycle expiry pulse
   always_ff @(posedge clk)
   begin
      if (reset)
         expired_ff <= 1'b0;
      else
         expired_ff <= tick && !clear && (count_ff == terminal);
   end
endmodule // kww_postscale
`default_nettype wire

// ==== hdl/kww_watchdog.sv ====
// keyed windowed watchdog with its Avalon-MM register slave
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "kww_cfg.svh"
module kww_watchdog (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [15:0] avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWriteData,
   input  wire logic [3:0]  avsByteEnable,
   output logic      [31:0] avsReadData,
   output logic             avsWaitRequest,
   input  wire logic        lowPowerRcClock,
   input  wire logic        configWatchdogEnable,
   input  wire logic [4:0]  configPostscaleSetting,
   input  wire logic        sleepMode,
   input  wire logic        idleMode,
   output logic             deviceReset,
   output logic             wakeRequest,
   output logic             irq
);
   logic                    waitReq_ff;
   logic [31:0]             readData_ff;
   logic                    on_ff;
   logic                    windowModeEnable_ff;
   kww_pkg::kww_scale_t     runPostscaleValue_ff;
   logic                    needLoad_ff;
   logic                    rcPrev_ff;
   logic [`KWW_EVT_W-1:0]   status_ff;
   logic [`KWW_EVT_W-1:0]   irqEnable_ff;
   logic                    deviceReset_ff;
   logic                    wakeRequest_ff;
   logic                    irq_ff;
   logic                    access;
   logic                    request;
   logic [31:0]             byteMask;
   logic [31:0]             ctrlView;
   logic [31:0]             ctrlWrMask;
   logic [31:0]             nxt_ctrl;
   logic [31:0]             nxt_readData;
   logic                    ctrlHit;
   logic                    keyWrite;
   logic                    keyHit;
   logic                    badKey;
   logic                    windowViolation;
   logic                    wdtEnable;
   logic                    rcTick;
   logic                    lowPower;
   logic                    expired;
   logic                    halfDone;
   logic                    counterClear;
   logic [`KWW_CNT_W-1:0]   count;
   logic [`KWW_EVT_W-1:0]   events;

   assign avsWaitRequest = waitReq_ff;
   assign avsReadData    = readData_ff;
   assign deviceReset    = deviceReset_ff;
   assign wakeRequest    = wakeRequest_ff;
   assign irq            = irq_ff;

   // bus request decode
   assign request  = avsRead || avsWrite;
   assign access   = request && !waitReq_ff;
   assign byteMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                      {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
   assign ctrlHit  = (avsAddress == `KWW_ADDR_CTRL);

   // only the enable and window bits accept writes
   assign ctrlWrMask = byteMask & ((32'h00000001 << `KWW_BIT_ON)
                                 | (32'h00000001 << `KWW_BIT_WIN));

   // control as read: key reads zero, unimplemented bits zero
   always_comb
   begin
      ctrlView = 32'h00000000;
      ctrlView[`KWW_BIT_ON] = on_ff;
      ctrlView[`KWW_RUN_MSB:`KWW_RUN_LSB] = runPostscaleValue_ff;
      ctrlView[`KWW_BIT_WIN] = windowModeEnable_ff;
   end

   // key detection on the upper half-word
   assign keyWrite = access && avsWrite && ctrlHit
                     && (avsByteEnable[3] || avsByteEnable[2]);
   assign keyHit   = keyWrite && (avsByteEnable == `KWW_KEY_BE)
                     && (avsWriteData[31:`KWW_KEY_LSB] == `KWW_KEY);
   assign badKey   = keyWrite && !keyHit;
   // early restart in windowed mode counts as a failure
   assign windowViolation = keyHit && wdtEnable && windowModeEnable_ff
                            && !halfDone;

   // config enable overrides the software bit
   assign wdtEnable = configWatchdogEnable || on_ff;

   // rising edge of the low-power RC clock
   assign rcTick   = wdtEnable && lowPowerRcClock && !rcPrev_ff;
   assign lowPower = sleepMode || idleMode;
   assign counterClear = !wdtEnable || keyHit;

   kww_postscale u_postscale (
      .clk      (clk),
      .reset    (reset),
      .clear    (counterClear),
      .tick     (rcTick),
      .scale    (runPostscaleValue_ff),
      .count    (count),
      .expired  (expired),
      .halfDone (halfDone)
   );

   // edge memory of the RC clock
   always_ff @(posedge clk)
   begin
      if (reset)
         rcPrev_ff <= 1'b0;
      else
         rcPrev_ff <= lowPowerRcClock;
   end

   // one wait cycle, then one cycle of answer
   always_ff @(posedge clk)
   begin
      if (reset)
         waitReq_ff <= 1'b1;
      else
         waitReq_ff <= !(request && waitReq_ff);
   end

   // read data mux, captured as wait drops
   always_comb
   begin
      nxt_readData = 32'h00000000;
      case (avsAddress)
         `KWW_ADDR_CTRL: nxt_readData = ctrlView;
         `KWW_ADDR_STAT: nxt_readData = {28'h0000000, status_ff};
         `KWW_ADDR_IEN:  nxt_readData = {28'h0000000, irqEnable_ff};
         `KWW_ADDR_CNT:  nxt_readData = {12'h000, count};
         default:        nxt_readData = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         readData_ff <= 32'h00000000;
      else if (avsRead && waitReq_ff)
         readData_ff <= nxt_readData;
      else if (!request)
         readData_ff <= 32'h00000000;
   end

   // direct, clear, set and invert writes to control
   always_comb
   begin
      nxt_ctrl = ctrlView;
      case (avsAddress)
         `KWW_ADDR_CTRL: nxt_ctrl = (ctrlView & ~ctrlWrMask)
                                  | (avsWriteData & ctrlWrMask);
         `KWW_ADDR_CLR:  nxt_ctrl = ctrlView
                                  & ~(avsWriteData & ctrlWrMask);
         `KWW_ADDR_SET:  nxt_ctrl = ctrlView
                                  | (avsWriteData & ctrlWrMask);
         `KWW_ADDR_INV:  nxt_ctrl = ctrlView
                                  ^ (avsWriteData & ctrlWrMask);
         default:        nxt_ctrl = ctrlView;
      endcase
   end

   // software enable bit
   always_ff @(posedge clk)
   begin
      if (reset)
         on_ff <= `KWW_ON_RST;
      else if (access && avsWrite)
         on_ff <= nxt_ctrl[`KWW_BIT_ON];
   end

   // window mode select
   always_ff @(posedge clk)
   begin
      if (reset)
         windowModeEnable_ff <= `KWW_WIN_RST;
      else if (access && avsWrite)
         windowModeEnable_ff <= nxt_ctrl[`KWW_BIT_WIN];
   end

   // postscale loaded after reset release, then tracks Run mode
   always_ff @(posedge clk)
   begin
      if (reset)
         needLoad_ff <= 1'b1;
      else
         needLoad_ff <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         runPostscaleValue_ff <= `KWW_RUN_RST;
      else if (needLoad_ff)
         runPostscaleValue_ff <= configPostscaleSetting;
      else if (!lowPower)
         runPostscaleValue_ff <= configPostscaleSetting;
   end

   // device reset on time-out in Run mode or window failure
   always_ff @(posedge clk)
   begin
      if (reset)
         deviceReset_ff <= 1'b0;
      else
         deviceReset_ff <= (expired && !lowPower) || windowViolation;
   end

   // wake in place of reset while asleep or idle
   always_ff @(posedge clk)
   begin
      if (reset)
         wakeRequest_ff <= 1'b0;
      else
         wakeRequest_ff <= expired && lowPower;
   end

   // event bits, each a one-cycle cause
   always_comb
   begin
      events = `KWW_EVT_RST;
      events[kww_pkg::KWW_EVT_TIMEOUT] = expired && !lowPower;
      events[kww_pkg::KWW_EVT_WAKE]    = expired && lowPower;
      events[kww_pkg::KWW_EVT_WINDOW]  = windowViolation;
      events[kww_pkg::KWW_EVT_BADKEY]  = badKey;
   end

   // sticky status, a new event wins over the clear
   always_ff @(posedge clk)
   begin
      if (reset)
         status_ff <= `KWW_EVT_RST;
      else if (access && avsWrite && (avsAddress == `KWW_ADDR_STCLR))
         status_ff <= (status_ff & ~avsWriteData[`KWW_EVT_W-1:0]) | events;
      else
         status_ff <= status_ff | events;
   end

   // interrupt enable
   always_ff @(posedge clk)
   begin
      if (reset)
         irqEnable_ff <= `KWW_EVT_RST;
      else if (access && avsWrite && (avsAddress == `KWW_ADDR_IEN)
               && avsByteEnable[0])
         irqEnable_ff <= avsWriteData[`KWW_EVT_W-1:0];
   end

   // level interrupt
   always_ff @(posedge clk)
   begin
      if (reset)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(status_ff & irqEnable_ff);
   end

   // checks next to the logic they guard
   key_restart_a: assert property (
      @(posedge clk) disable iff (reset)
      keyHit |=> (count == '0))
      else $error("valid key did not clear the counter");

   split_key_a: assert property (
      @(posedge clk) disable iff (reset)
      (keyWrite && (avsByteEnable != `KWW_KEY_BE))
      |=> status_ff[kww_pkg::KWW_EVT_BADKEY])
      else $error("wide or split key write not flagged");

   disabled_clear_a: assert property (
      @(posedge clk) disable iff (reset)
      !wdtEnable |=> (count == '0))
      else $error("counter moved while disabled");

   tick_only_a: assert property (
      @(posedge clk) disable iff (reset)
      (!rcTick && !counterClear) |=> $stable(count))
      else $error("counter moved without an RC edge");

   timeout_reset_a: assert property (
      @(posedge clk) disable iff (reset)
      (expired && !lowPower) |=> deviceReset_ff ##1 !deviceReset_ff)
      else $error("time-out did not pulse device reset");

   sleep_wake_a: assert property (
      @(posedge clk) disable iff (reset)
      (expired && lowPower && !windowViolation)
      |=> (wakeRequest_ff && !deviceReset_ff))
      else $error("time-out in low power did not wake");

   config_enable_a: assert property (
      @(posedge clk) disable iff (reset)
      configWatchdogEnable |-> wdtEnable)
      else $error("config enable did not force the watchdog on");

   run_follow_a: assert property (
      @(posedge clk) disable iff (reset)
      (!lowPower && !needLoad_ff) ##1 !lowPower
      |-> (runPostscaleValue_ff == $past(configPostscaleSetting)))
      else $error("run postscale does not follow config");

   unimpl_zero_a: assert property (
      @(posedge clk) disable iff (reset)
      (avsRead && waitReq_ff && ctrlHit)
      |=> (readData_ff[31:16] == 16'h0000)
          && (readData_ff[14:13] == 2'h0) && (readData_ff[7:1] == 7'h00))
      else $error("unimplemented control bits read nonzero");

   alias_set_a: assert property (
      @(posedge clk) disable iff (reset)
      (access && avsWrite && (avsAddress == `KWW_ADDR_SET)
       && avsByteEnable[0] && avsWriteData[`KWW_BIT_WIN])
      |=> windowModeEnable_ff)
      else $error("set alias did not set window mode");

   bus_answer_a: assert property (
      @(posedge clk) disable iff (reset)
      (request && waitReq_ff) |=> !waitReq_ff ##1 waitReq_ff)
      else $error("slave did not answer in one cycle");
endmodule // kww_watchdog
`default_nettype wire

// ==== tb/kww_watchdog_tb_top.sv ====
// self-checking bench of the keyed windowed watchdog
`timescale 1ns/1ps
`default_nettype none
`include "kww_cfg.svh"
module kww_watchdog_tb_top;
   typedef struct
   {
      logic [15:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
   } kww_row_t;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] avsAddress = 16'h0000;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h00000000;
   logic [3:0]  avsByteEnable = 4'h0;
   logic [31:0] avsReadData;
   logic        avsWaitRequest;
   logic        rcClk = 1'b0;
   logic        cfgEnable = 1'b0;
   logic [4:0]  cfgScale = 5'h02;
   logic        sleepMode = 1'b0;
   logic        idleMode = 1'b0;
   logic        deviceReset;
   logic        wakeRequest;
   logic        irq;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          nRst = 0;
   int          nWake = 0;
   int          base;
   logic [31:0] rd;
   kww_row_t    rows [7];

   kww_watchdog i_kww_watchdog (
      .clk(clk), .reset(reset), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .lowPowerRcClock(rcClk), .configWatchdogEnable(cfgEnable),
      .configPostscaleSetting(cfgScale), .sleepMode(sleepMode),
      .idleMode(idleMode), .deviceReset(deviceReset),
      .wakeRequest(wakeRequest), .irq(irq)
   );

   // 20 MHz clock
   always #25 clk = ~clk;

   // pulse counters and hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (deviceReset === 1'b1) nRst++;
      if (wakeRequest === 1'b1) nWake++;
      if (cycles == 3000)
      begin
         n_fail++;
         final_report();
      end
   end

   // verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (got !== exp)
         begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
         end
   endtask

   // avalon write, held until waitrequest sampled low
   task automatic busWrite(input logic [15:0] a, input logic [31:0] d,
                           input logic [3:0] be);
      avsAddress    <= a;
      avsWriteData  <= d;
      avsByteEnable <= be;
      avsWrite      <= 1'b1;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      avsWrite <= 1'b0;
      @(posedge clk);
   endtask

   // avalon read, data taken at the accepting edge
   task automatic busRead(input logic [15:0] a, output logic [31:0] d);
      avsAddress <= a;
      avsRead    <= 1'b1;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      d = avsReadData;
      avsRead <= 1'b0;
      @(posedge clk);
   endtask

   // rc clock rising edges, two system cycles each
   task automatic tick(input int n);
      repeat (n)
      begin
         rcClk <= 1'b1;
         @(posedge clk);
         rcClk <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic key(input logic [3:0] be, input logic [15:0] k);
      // low half keeps the enable set should a wide write reach lane 1
      busWrite(`KWW_ADDR_CTRL, {k, 16'h8000}, be);
   endtask

   // main sequence
   initial
   begin
      rows[0] = '{`KWW_ADDR_CTRL, 32'h0000FFFF, 32'h00008201};
      rows[1] = '{`KWW_ADDR_CLR,  32'h00008000, 32'h00000201};
      rows[2] = '{`KWW_ADDR_SET,  32'h0000FFFF, 32'h00008201};
      rows[3] = '{`KWW_ADDR_INV,  32'h00008001, 32'h00000200};
      rows[4] = '{`KWW_ADDR_INV,  32'h00000001, 32'h00000201};
      rows[5] = '{`KWW_ADDR_CLR,  32'h0000FFFF, 32'h00000200};
      rows[6] = '{16'hF700,       32'h0000FFFF, 32'h00000200};
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      busRead(`KWW_ADDR_CTRL, rd);
      check(rd, 32'h00000200, "ctrl after reset");
      foreach (rows[i])
      begin
         busWrite(rows[i].addr, rows[i].data, 4'h3);
         busRead(`KWW_ADDR_CTRL, rd);
         check(rd, rows[i].exp, "ctrl row");
      end
      busRead(16'hF700, rd);
      check(rd, 32'h00000000, "unmapped read");
      // time-out after exactly four ticks
      base = nRst;
      busWrite(`KWW_ADDR_SET, 32'h00008000, 4'h3);
      tick(3);
      check(nRst - base, 0, "early reset");
      tick(1);
      repeat (3) @(posedge clk);
      check(nRst - base, 1, "time-out reset");
      // valid keys keep it alive, bad keys do not
      for (int i = 0; i < 6; i++)
      begin
         tick(3);
         key(4'hC, `KWW_KEY);
      end
      check(nRst - base, 1, "reset despite key");
      tick(3);
      key(4'hC, 16'h1234);
      key(4'hF, `KWW_KEY);
      tick(1);
      repeat (3) @(posedge clk);
      check(nRst - base, 2, "bad key restarted");
      busWrite(`KWW_ADDR_CLR, 32'h00008000, 4'h3);
      // configuration enable overrides the control bit
      cfgEnable <= 1'b1;
      tick(4);
      repeat (3) @(posedge clk);
      check(nRst - base, 3, "config enable");
      cfgEnable <= 1'b0;
      tick(6);
      check(nRst - base, 3, "runs while disabled");
      // time-out in sleep wakes instead
      sleepMode <= 1'b1;
      busWrite(`KWW_ADDR_SET, 32'h00008000, 4'h3);
      tick(4);
      repeat (3) @(posedge clk);
      check(nWake, 1, "wake pulse");
      check(nRst - base, 3, "reset in sleep");
      busWrite(`KWW_ADDR_CLR, 32'h00008000, 4'h3);
      sleepMode <= 1'b0;
      // idle wakes as well, counter reads back mid-period
      idleMode <= 1'b1;
      busWrite(`KWW_ADDR_SET, 32'h00008000, 4'h3);
      tick(2);
      busRead(`KWW_ADDR_CNT, rd);
      check(rd, 32'h00000002, "counter readback");
      tick(2);
      repeat (3) @(posedge clk);
      check(nWake, 2, "idle wake");
      check(nRst - base, 3, "reset in idle");
      busWrite(`KWW_ADDR_CLR, 32'h00008000, 4'h3);
      idleMode <= 1'b0;
      // early keys in window mode reset the device
      busWrite(`KWW_ADDR_SET, 32'h00008001, 4'h3);
      key(4'hC, `KWW_KEY);
      key(4'hC, `KWW_KEY);
      repeat (2) @(posedge clk);
      check(nRst - base, 5, "window violation");
      busWrite(`KWW_ADDR_CLR, 32'h00008001, 4'h3);
      // sticky status, mask and clear of the interrupt
      busRead(`KWW_ADDR_STAT, rd);
      check(rd, 32'h0000000F, "status");
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq masked");
      busWrite(`KWW_ADDR_IEN, 32'h00000004, 4'hF);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1, "irq enabled");
      busWrite(`KWW_ADDR_STCLR, 32'h0000000F, 4'hF);
      busRead(`KWW_ADDR_STAT, rd);
      check(rd, 32'h0, "status cleared");
      check({31'h0, irq}, 32'h0, "irq cleared");
      // run field follows configuration, then a second reset
      cfgScale <= 5'h05;
      busWrite(`KWW_ADDR_SET, 32'h00001F00, 4'h3);
      busRead(`KWW_ADDR_CTRL, rd);
      check(rd, 32'h00000500, "run field");
      reset <= 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      busRead(`KWW_ADDR_CTRL, rd);
      check(rd, 32'h00000500, "ctrl after second reset");
      final_report();
   end
endmodule // kww_watchdog_tb_top
`default_nettype wire
